/* common/iol_pkg.sv */
// constants and types for the io-link port validation and backup block
// assumes a 50 mhz system clock and one port per instance
package iol_pkg;
	// validation level codes
	localparam logic [1:0] LVL_NONE = 2'h0;
	localparam logic [1:0] LVL_V10 = 2'h1;
	localparam logic [1:0] LVL_V11 = 2'h2;
	localparam logic [1:0] LVL_V11_BR = 2'h3;
	localparam logic [1:0] LVL_RESET = LVL_NONE;
	// cycle selection codes, 0 is fastest possible
	localparam logic [3:0] CYC_FAST = 4'h0;
	localparam logic [3:0] CYC_1P6 = 4'h1;
	localparam logic [3:0] CYC_3P2 = 4'h2;
	localparam logic [3:0] CYC_4P8 = 4'h3;
	localparam logic [3:0] CYC_8 = 4'h4;
	localparam logic [3:0] CYC_20P8 = 4'h5;
	localparam logic [3:0] CYC_40 = 4'h6;
	localparam logic [3:0] CYC_80 = 4'h7;
	localparam logic [3:0] CYC_120 = 4'h8;
	localparam logic [3:0] CYC_RESET = CYC_FAST;
	// cycle periods in units of 100 us
	localparam logic [11:0] PER_1P6 = 12'h010;
	localparam logic [11:0] PER_3P2 = 12'h020;
	localparam logic [11:0] PER_4P8 = 12'h030;
	localparam logic [11:0] PER_8 = 12'h050;
	localparam logic [11:0] PER_20P8 = 12'h0d0;
	localparam logic [11:0] PER_40 = 12'h190;
	localparam logic [11:0] PER_80 = 12'h320;
	localparam logic [11:0] PER_120 = 12'h4b0;
	// shortest period the master itself supports
	localparam logic [11:0] PER_MASTER_MIN = PER_1P6;
	// identifier reset values
	localparam logic [15:0] VID_RESET = 16'h0000;
	localparam logic [15:0] DID_RESET = 16'h0000;
	// store command that raises the device upload request
	localparam logic [15:0] STORE_INDEX = 16'h0002;
	localparam logic [7:0] STORE_SUBINDEX = 8'h00;
	localparam logic [7:0] STORE_VALUE = 8'h05;
	// port sequencing states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_DECIDE,
		ST_BACKUP,
		ST_RESTORE,
		ST_OPERATE,
		ST_MISMATCH
	} state_type;
endpackage : iol_pkg

/* verilog/id_check.sv */
// one identifier comparison for the port validation block
// assumes expected and reported values are stable while compared
`timescale 1ns/1ns
`default_nettype none
module id_check
#(
	parameter int WIDTH = 16 // identifier width
)
(
	input wire logic enable_in, // compare only when high
	input wire logic [WIDTH-1:0] expected_in, // configured value
	input wire logic [WIDTH-1:0] reported_in, // value from device
	output logic match_out // high when equal or not checked
);
	// a disabled check passes, so the caller needs no extra gating
	always_comb
	begin
		match_out = !enable_in || (expected_in == reported_in);
	end
endmodule : id_check
`default_nettype wire

/* verilog/iol_port_validation_backup.sv */
// per-port validation, backup/restore decision and cycle selection
// assumes same-clock device inputs and an engine doing the transfers
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RQ1: four validation levels selectable per port
// RQ2: no-check level skips ids, backup, restore
// RQ3: v1.1 levels compare vendor and device ids
// RQ4: backup or restore only after type check passes
// RQ5: no valid stored set means upload parameters
// RQ6: store command sets upload flag, triggers backup
// RQ7: on attach, restore differing set unless locked
// RQ8: restore only with existing, suitable stored set
// RQ9: backup versus restore choice by data states
// RQ10: device raises upload flag after block writes
// RQ11: fastest option uses device period, master bounded
// RQ12: fixed periods 1.6 to 120 ms applied
// RQ13: vendor and device ids configurable, default zero
// RQ14: reset gives no check and fastest period
// RQ15: settings only act in manual port mode
// RQ16: id failure withholds data, flags mismatch
module iol_port_validation_backup
	import iol_pkg::*;
(
	input wire logic clk_in, // 50 mhz system clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic clk_en_in, // freezes all state when low
	input wire logic manual_mode_in, // 1 manual, 0 autostart
	input wire logic cfg_load_in, // pulse, latch settings below
	input wire logic [1:0] level_cfg_in, // validation level
	input wire logic [3:0] cycle_cfg_in, // cycle selection
	input wire logic [15:0] vendor_cfg_in, // expected vendor id
	input wire logic [15:0] device_cfg_in, // expected device id
	input wire logic store_clear_in, // pulse, discard stored set
	input wire logic dev_attach_in, // pulse, new device seen
	input wire logic dev_detach_in, // pulse, device lost
	input wire logic [15:0] dev_vendor_in, // reported vendor id
	input wire logic [15:0] dev_device_in, // reported device id
	input wire logic [11:0] dev_min_cycle_in, // device min period
	input wire logic dev_data_valid_in, // device set valid
	input wire logic upload_request_flag_in, // device flag
	input wire logic dev_locked_in, // device storage locked
	input wire logic params_equal_in, // stored equals device
	input wire logic xfer_done_in, // pulse, transfer finished
	input wire logic cmd_write_in, // pulse, acyclic write
	input wire logic [15:0] cmd_index_in, // write index
	input wire logic [7:0] cmd_subindex_in, // write subindex
	input wire logic [7:0] cmd_value_in, // write value
	output logic param_store_command_out, // pulse, set flag
	output logic backup_start_out, // pulse, begin upload
	output logic restore_start_out, // pulse, begin download
	output logic busy_out, // transfer in progress
	output logic pd_enable_out, // process data allowed
	output logic mismatch_out, // identifier mismatch
	output logic stored_valid_out, // stored set present
	output logic [11:0] cycle_period_out // period, 100 us units
);
	// latched configuration
	logic [1:0] level_q, level_d; // selected level
	logic [3:0] cycle_q, cycle_d; // selected cycle option
	logic [15:0] vid_q, vid_d; // expected vendor id
	logic [15:0] did_q, did_d; // expected device id
	// stored parameter set bookkeeping
	logic stored_q, stored_d; // stored set valid
	logic [15:0] svid_q, svid_d; // vendor id of stored set
	logic [15:0] sdid_q, sdid_d; // device id of stored set
	// sequencing
	state_type state_q, state_d; // port state
	logic bstart_q, bstart_d; // backup start pulse
	logic rstart_q, rstart_d; // restore start pulse
	logic cmd_q, cmd_d; // store command pulse
	logic [11:0] per_q, per_d; // applied period
	// derived terms
	logic [1:0] eff_level; // level in force
	logic id_on; // identifiers checked
	logic vid_ok, did_ok; // vendor and device ids match
	logic suits; // stored set suits device
	logic [11:0] fast_per; // fastest usable period
	// autostart forces no check, whatever was configured
	// RQ15 manual mode gate
	assign eff_level = manual_mode_in ? level_q : LVL_NONE;
	// RQ3 v1.1 id check
	assign id_on = (eff_level == LVL_V11) || (eff_level == LVL_V11_BR);
	assign suits = (svid_q == dev_vendor_in) && (sdid_q == dev_device_in);
	// RQ11 bounded fastest
	assign fast_per = (dev_min_cycle_in > PER_MASTER_MIN) ?
		dev_min_cycle_in : PER_MASTER_MIN;
	// vendor identifier comparison
	id_check #(.WIDTH(16)) u_vid_check (
		.enable_in(id_on),
		.expected_in(vid_q),
		.reported_in(dev_vendor_in),
		.match_out(vid_ok)
	);
	// device identifier comparison
	id_check #(.WIDTH(16)) u_did_check (
		.enable_in(id_on),
		.expected_in(did_q),
		.reported_in(dev_device_in),
		.match_out(did_ok)
	);
	// configuration latch and period selection
	always_comb
	begin
		level_d = level_q;
		cycle_d = cycle_q;
		vid_d = vid_q;
		did_d = did_q;
		// RQ1 level latch
		if (cfg_load_in)
		begin
			level_d = level_cfg_in;
			cycle_d = cycle_cfg_in;
			// RQ13 id settings
			vid_d = vendor_cfg_in;
			did_d = device_cfg_in;
		end
		// RQ12 fixed periods
		unique case (manual_mode_in ? cycle_q : CYC_FAST)
			CYC_1P6: per_d = PER_1P6;
			CYC_3P2: per_d = PER_3P2;
			CYC_4P8: per_d = PER_4P8;
			CYC_8: per_d = PER_8;
			CYC_20P8: per_d = PER_20P8;
			CYC_40: per_d = PER_40;
			CYC_80: per_d = PER_80;
			CYC_120: per_d = PER_120;
			// unknown codes fall back to fastest
			default: per_d = fast_per;
		endcase
	end
	// store command decode, independent of port state
	// RQ6 store command decode
	always_comb
		cmd_d = cmd_write_in && (cmd_index_in == STORE_INDEX) &&
			(cmd_subindex_in == STORE_SUBINDEX) &&
			(cmd_value_in == STORE_VALUE);
	// port sequencing and stored set bookkeeping
	always_comb
	begin
		state_d = state_q;
		stored_d = stored_q;
		svid_d = svid_q;
		sdid_d = sdid_q;
		bstart_d = 1'b0;
		rstart_d = 1'b0;
		unique case (state_q)
			ST_IDLE:
				if (dev_attach_in)
					state_d = ST_CHECK;
			ST_CHECK:
				// RQ16 mismatch holds data
				if (!(vid_ok && did_ok))
					state_d = ST_MISMATCH;
				// RQ4 transfer after check
				else if (eff_level == LVL_V11_BR)
					state_d = ST_DECIDE;
				// RQ2 no backup level, no transfer
				else
					state_d = ST_OPERATE;
			ST_DECIDE:
				// RQ9 RQ5 backup when none stored
				if ((!stored_q && dev_data_valid_in) ||
					upload_request_flag_in)
				begin
					bstart_d = 1'b1;
					state_d = ST_BACKUP;
				end
				// RQ7 RQ8 restore suitable differing set
				else if (stored_q && suits && !params_equal_in &&
					!dev_locked_in)
				begin
					rstart_d = 1'b1;
					state_d = ST_RESTORE;
				end
				else
					state_d = ST_OPERATE;
			ST_BACKUP:
				if (xfer_done_in)
				begin
					stored_d = 1'b1;
					svid_d = dev_vendor_in;
					sdid_d = dev_device_in;
					state_d = ST_OPERATE;
				end
			ST_RESTORE:
				if (xfer_done_in)
					state_d = ST_OPERATE;
			ST_OPERATE:
				// RQ6 flag seen, upload again
				if (eff_level == LVL_V11_BR && upload_request_flag_in)
				begin
					bstart_d = 1'b1;
					state_d = ST_BACKUP;
				end
			ST_MISMATCH:
				// stays until the device goes away
				state_d = ST_MISMATCH;
		endcase
		// a clear during a backup loses to the backup's completion
		if (store_clear_in && !(state_q == ST_BACKUP && xfer_done_in))
			stored_d = 1'b0;
		// detach aborts any sequence, even a transfer in flight
		if (dev_detach_in)
		begin
			state_d = ST_IDLE;
			bstart_d = 1'b0;
			rstart_d = 1'b0;
		end
	end
	// all registers, frozen while the clock enable is low
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			// RQ14 reset defaults
			level_q <= LVL_RESET;
			cycle_q <= CYC_RESET;
			vid_q <= VID_RESET;
			did_q <= DID_RESET;
			stored_q <= 1'b0;
			svid_q <= VID_RESET;
			sdid_q <= DID_RESET;
			state_q <= ST_IDLE;
			bstart_q <= 1'b0;
			rstart_q <= 1'b0;
			cmd_q <= 1'b0;
			per_q <= PER_MASTER_MIN;
		end
		else if (clk_en_in)
		begin
			level_q <= level_d;
			cycle_q <= cycle_d;
			vid_q <= vid_d;
			did_q <= did_d;
			stored_q <= stored_d;
			svid_q <= svid_d;
			sdid_q <= sdid_d;
			state_q <= state_d;
			bstart_q <= bstart_d;
			rstart_q <= rstart_d;
			cmd_q <= cmd_d;
			per_q <= per_d;
		end
	end
	// outputs straight from flip-flops or state decode
	assign param_store_command_out = cmd_q;
	assign backup_start_out = bstart_q;
	assign restore_start_out = rstart_q;
	assign busy_out = (state_q == ST_BACKUP) || (state_q == ST_RESTORE);
	assign pd_enable_out = (state_q == ST_OPERATE);
	assign mismatch_out = (state_q == ST_MISMATCH);
	assign stored_valid_out = stored_q;
	assign cycle_period_out = per_q;
	a_mismatch_blocks_pd: assert property (@(posedge clk_in) // RQ16
		disable iff (!rst_n_in) mismatch_out |-> !pd_enable_out)
		else $error("process data enabled during mismatch");
	a_idfail_to_mismatch: assert property (@(posedge clk_in) // RQ3
		disable iff (!rst_n_in)
		(clk_en_in && state_q == ST_CHECK && !vid_ok && !dev_detach_in)
		|=> mismatch_out)
		else $error("id failure did not raise mismatch");
	a_none_no_backup: assert property (@(posedge clk_in) // RQ2
		disable iff (!rst_n_in)
		(eff_level == LVL_NONE && state_q == ST_CHECK)
		|=> !busy_out ##1 !busy_out)
		else $error("transfer started at no-check level");
	a_start_needs_check: assert property (@(posedge clk_in) // RQ4
		disable iff (!rst_n_in)
		$rose(backup_start_out) || $rose(restore_start_out)
		|-> $past(state_q) == ST_DECIDE || $past(state_q) == ST_OPERATE)
		else $error("transfer started without type check");
	a_empty_store_backup: assert property (@(posedge clk_in) // RQ5
		disable iff (!rst_n_in)
		(clk_en_in && state_q == ST_DECIDE && !stored_q &&
		dev_data_valid_in && !dev_detach_in)
		|=> backup_start_out && busy_out)
		else $error("empty store did not trigger backup");
	a_store_cmd_pulse: assert property (@(posedge clk_in) // RQ6
		disable iff (!rst_n_in)
		(clk_en_in && cmd_write_in && cmd_index_in == STORE_INDEX &&
		cmd_subindex_in == STORE_SUBINDEX &&
		cmd_value_in == STORE_VALUE) |=> param_store_command_out)
		else $error("store command not forwarded");
	a_locked_no_restore: assert property (@(posedge clk_in) // RQ7
		disable iff (!rst_n_in)
		(state_q == ST_DECIDE && dev_locked_in) |=> !restore_start_out)
		else $error("restore despite locked storage");
	a_restore_needs_set: assert property (@(posedge clk_in) // RQ8
		disable iff (!rst_n_in)
		restore_start_out |-> $past(stored_q) && $past(suits))
		else $error("restore without suitable stored set");
	a_fixed_period: assert property (@(posedge clk_in) // RQ12
		disable iff (!rst_n_in)
		(clk_en_in && manual_mode_in && cycle_q == CYC_120)
		|=> cycle_period_out == PER_120)
		else $error("fixed period not applied");
	a_fast_bounded: assert property (@(posedge clk_in) // RQ11
		disable iff (!rst_n_in)
		cycle_period_out >= PER_MASTER_MIN)
		else $error("period below master minimum");
endmodule : iol_port_validation_backup
`default_nettype wire

/* tb/dev_model.sv */
// behavioural io-link device facing the port block
// assumes the block's clock and reset; ids and data state come from tb
`timescale 1ns/1ns
`default_nettype none
module dev_model
(
	input wire logic clk_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic slow_in, // long transfers when high
	input wire logic block_write_in, // pulse, block mode write
	input wire logic store_cmd_in, // pulse, store command
	input wire logic start_in, // pulse, any transfer start
	input wire logic backup_in, // pulse, upload start
	output logic flag_out, // upload request flag
	output logic done_out // pulse, transfer finished
);
	logic [4:0] cnt_q; // cycles left in transfer
	logic up_q; // running transfer is an upload
	// transfer timing and upload flag
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			flag_out <= 1'b0;
			done_out <= 1'b0;
			cnt_q <= 5'h00;
			up_q <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			if (start_in)
			begin
				cnt_q <= slow_in ? 5'h10 : 5'h02;
				up_q <= backup_in;
			end
			else if (cnt_q != 5'h00)
			begin
				cnt_q <= cnt_q - 5'h01;
				// flag dropped as the upload ends
				if (cnt_q == 5'h01)
				begin
					done_out <= 1'b1;
					if (up_q)
						flag_out <= 1'b0;
				end
			end
			// flag raised by store or block write
			if (store_cmd_in || block_write_in)
				flag_out <= 1'b1;
		end
	end
endmodule : dev_model
`default_nettype wire

/* tb/tb_iol_port_validation_backup.sv */
// self-checking bench for the port validation and backup block
// assumes the device model answers transfers on the same clock
`timescale 1ns/1ns
`default_nettype none
module tb_iol_port_validation_backup
	import iol_pkg::*;
;
	logic clk_in = 1'b0, rst_n_in = 1'b0, manual_mode_in = 1'b0;
	logic cfg_load_in = 1'b0, store_clear_in = 1'b0, dev_attach_in = 1'b0;
	logic dev_detach_in = 1'b0, dev_data_valid_in = 1'b1;
	logic dev_locked_in = 1'b0, params_equal_in = 1'b0, cmd_write_in = 1'b0;
	logic slow = 1'b0, block_write = 1'b0, clk_en_in = 1'b1;
	logic [1:0] level_cfg_in = 2'h0;
	logic [3:0] cycle_cfg_in = 4'h0;
	logic [7:0] cmd_subindex_in = 8'h00, cmd_value_in = 8'h00;
	logic [11:0] dev_min_cycle_in = 12'h008;
	logic [15:0] vendor_cfg_in = 16'h0000, device_cfg_in = 16'h0042;
	logic [15:0] dev_vendor_in = 16'h1234, dev_device_in = 16'h0042;
	logic [15:0] cmd_index_in = 16'h0002;
	logic upload_request_flag_in, xfer_done_in; // from device model
	logic param_store_command_out, backup_start_out, restore_start_out;
	logic busy_out, pd_enable_out, mismatch_out, stored_valid_out;
	logic [11:0] cycle_period_out;
	logic [11:0] tbl [8]; // fixed periods in code order
	int fails, total_checks, bk_n, rs_n;
	iol_port_validation_backup uut (.clk_in, .rst_n_in, .clk_en_in,
		.manual_mode_in, .cfg_load_in, .level_cfg_in, .cycle_cfg_in,
		.vendor_cfg_in, .device_cfg_in, .store_clear_in, .dev_attach_in,
		.dev_detach_in, .dev_vendor_in, .dev_device_in, .dev_min_cycle_in,
		.dev_data_valid_in, .upload_request_flag_in, .dev_locked_in,
		.params_equal_in, .xfer_done_in, .cmd_write_in, .cmd_index_in,
		.cmd_subindex_in, .cmd_value_in, .param_store_command_out,
		.backup_start_out, .restore_start_out, .busy_out, .pd_enable_out,
		.mismatch_out, .stored_valid_out, .cycle_period_out);
	dev_model dev (.clk_in, .rst_n_in, .slow_in(slow),
		.block_write_in(block_write), .store_cmd_in(param_store_command_out),
		.start_in(backup_start_out | restore_start_out),
		.backup_in(backup_start_out), .flag_out(upload_request_flag_in),
		.done_out(xfer_done_in));
	// 50 mhz clock
	initial
	begin
		forever #10 clk_in = ~clk_in;
	end
	// transfer start pulses, counted one edge late
	always @(posedge clk_in)
	begin
		bk_n += backup_start_out;
		rs_n += restore_start_out;
	end
	task automatic stop_test;
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask : cmp
	// bounded wait: 0 data on, 1 mismatch, 2 busy
	task automatic wait_o(input int sel);
		int n;
		n = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		while (!(sel == 0 ? pd_enable_out === 1'b1 : sel == 1 ?
			mismatch_out === 1'b1 : busy_out === 1'b1) && n < 40);
		cmp(16'h1, {15'h0, n < 40});
	endtask : wait_o
	task automatic cfg(input logic [1:0] l, input logic [3:0] c,
		input logic [15:0] v, input logic [11:0] e);
		@(posedge clk_in);
		level_cfg_in <= l;
		cycle_cfg_in <= c;
		vendor_cfg_in <= v;
		cfg_load_in <= 1'b1;
		@(posedge clk_in);
		cfg_load_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1 cmp({4'h0, e}, {4'h0, cycle_period_out});
	endtask : cfg
	// optional transfer, then final state and start counts
	task automatic settle(input logic m, input logic x, input int bk,
		input int rs);
		if (x)
			wait_o(2);
		wait_o(m);
		cmp({15'h0, m}, {15'h0, mismatch_out});
		cmp({15'h0, !m}, {15'h0, pd_enable_out});
		cmp(bk[15:0], bk_n[15:0]);
		cmp(rs[15:0], rs_n[15:0]);
	endtask : settle
	task automatic see(input logic m, input logic x, input int bk,
		input int rs);
		@(posedge clk_in);
		dev_attach_in <= 1'b1;
		@(posedge clk_in);
		dev_attach_in <= 1'b0;
		settle(m, x, bk, rs);
	endtask : see
	task automatic drop;
		@(posedge clk_in);
		dev_detach_in <= 1'b1;
		@(posedge clk_in);
		dev_detach_in <= 1'b0;
		@(posedge clk_in);
	endtask : drop
	task automatic cmd(input logic [7:0] v, input logic e);
		@(posedge clk_in);
		cmd_write_in <= 1'b1;
		cmd_value_in <= v;
		@(posedge clk_in);
		cmd_write_in <= 1'b0;
		// the pulse stands only in the cycle after the write
		#1 cmp({15'h0, e}, {15'h0, param_store_command_out});
		@(posedge clk_in);
	endtask : cmd
	// low clock enable must ignore loads and attaches
	task automatic freeze;
		@(posedge clk_in);
		clk_en_in <= 1'b0;
		cycle_cfg_in <= CYC_120;
		cfg_load_in <= 1'b1;
		dev_attach_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		clk_en_in <= 1'b1;
		cfg_load_in <= 1'b0;
		dev_attach_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1 cmp(16'h0025, {4'h0, cycle_period_out});
		cmp(16'h0, {15'h0, pd_enable_out});
	endtask : freeze
	// mid-run reset brings back level none and fastest period
	task automatic rerun;
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1 cmp(16'h0010, {4'h0, cycle_period_out});
		cmp(16'h0, {15'h0, stored_valid_out});
		see(0, 0, 3, 1);
	endtask : rerun
	// hang guard, far beyond the expected run
	initial
	begin
		#100000;
		fails++;
		stop_test();
	end
	initial
	begin
		tbl = '{PER_1P6, PER_3P2, PER_4P8, PER_8, PER_20P8, PER_40, PER_80,
			PER_120};
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1 cmp(16'h0010, {4'h0, cycle_period_out});
		@(posedge clk_in);
		manual_mode_in <= 1'b1;
		see(0, 0, 0, 0);
		drop();
		for (int i = 1; i < 9; i++)
			cfg(2'h0, i[3:0], 16'h0, tbl[i-1]);
		cfg(2'h0, CYC_FAST, 16'h0, 12'h010);
		cfg(2'h0, 4'hf, 16'h0, 12'h010);
		@(posedge clk_in);
		dev_min_cycle_in <= 12'h025;
		cfg(2'h3, CYC_FAST, 16'h0, 12'h025);
		cfg(2'h3, CYC_120, 16'h0, PER_120);
		// autostart overrides the latched level and period, which stay latched
		@(posedge clk_in);
		manual_mode_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1 cmp(16'h0025, {4'h0, cycle_period_out});
		see(0, 0, 0, 0);
		drop();
		manual_mode_in <= 1'b1;
		cfg(2'h1, CYC_FAST, 16'h0, 12'h025);
		see(0, 0, 0, 0);
		drop();
		cfg(2'h2, CYC_FAST, 16'h0, 12'h025);
		see(1, 0, 0, 0);
		drop();
		cfg(2'h2, CYC_FAST, 16'h1234, 12'h025);
		see(0, 0, 0, 0);
		drop();
		cfg(2'h3, CYC_FAST, 16'h0, 12'h025);
		see(1, 0, 0, 0);
		drop();
		cfg(2'h3, CYC_FAST, 16'h1234, 12'h025);
		see(0, 1, 1, 0);
		cmp(16'h1, {15'h0, stored_valid_out});
		drop();
		params_equal_in <= 1'b1;
		see(0, 0, 1, 0);
		drop();
		params_equal_in <= 1'b0;
		dev_locked_in <= 1'b1;
		see(0, 0, 1, 0);
		drop();
		dev_locked_in <= 1'b0;
		slow <= 1'b1;
		see(0, 1, 1, 1);
		cmd(8'h04, 1'b0);
		cmd(STORE_VALUE, 1'b1);
		settle(0, 1, 2, 1);
		cmp(16'h0, {15'h0, upload_request_flag_in});
		@(posedge clk_in);
		block_write <= 1'b1;
		@(posedge clk_in);
		block_write <= 1'b0;
		settle(0, 1, 3, 1);
		drop();
		store_clear_in <= 1'b1;
		dev_data_valid_in <= 1'b0;
		@(posedge clk_in);
		store_clear_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1 cmp(16'h0, {15'h0, stored_valid_out});
		see(0, 0, 3, 1);
		drop();
		freeze();
		rerun();
		stop_test();
	end
endmodule : tb_iol_port_validation_backup
`default_nettype wire
